/* hw/gpio_read_and_runtime_settings_cmd.sv */
`timescale 1ns/100ps
module gpio_read_and_runtime_settings_cmd (
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic [3:0]  general_pin_level_i,
    input  wire logic [3:0]  general_pin_is_gpio_i,
    input  wire logic [3:0]  general_pin_is_input_i,
    output logic [2:0]       clk_out_divider_o,
    output logic [1:0]       clk_out_duty_o,
    output logic [1:0]       dac_vref_level_o,
    output logic             dac_vref_internal_o,
    output logic [4:0]       dac_value_o
);
    // ==========================================================
    // pin synchroniser
    logic [3:0] lvl_meta;
    logic [3:0] lvl_sync;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lvl_meta <= 4'h0;
            lvl_sync <= 4'h0;
        end
        else if (ce_i)
        begin
            lvl_meta <= general_pin_level_i;
            lvl_sync <= lvl_meta;
        end
    end

    // ==========================================================
    // axi write channel
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        next_aw_held;
    logic [7:0]  next_aw_addr;
    logic        next_w_held;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        do_write;
    logic [7:0]  wr_word;
    logic        wr_mapped;

    // ready stays low while frozen so no beat is lost
    assign s_axi_awready_o = ce_i && !aw_held && !bvalid;
    assign s_axi_wready_o  = ce_i && !w_held && !bvalid;
    assign s_axi_bvalid_o  = bvalid;
    assign s_axi_bresp_o   = bresp;
    assign do_write        = ce_i && aw_held && w_held && !bvalid;
    assign wr_word         = {aw_addr[7:2], 2'b00};
    assign wr_mapped       = wr_word <= gpio_read_and_runtime_settings_cmd_pkg::OFF_SETTINGS;

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_mapped ? gpio_read_and_runtime_settings_cmd_pkg::AXI_OKAY
                                     : gpio_read_and_runtime_settings_cmd_pkg::AXI_SLVERR;
        end
        if (ce_i && bvalid && s_axi_bready_i)
        begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held  <= next_w_held;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
        end
    end

    // ==========================================================
    // command registers and execution
    logic [31:0] cmd0;
    logic [31:0] cmd1;
    logic        exec_pend;
    logic        resp_valid;
    logic [7:0]  resp [0:9];
    logic [4:0]  clk_cfg;
    logic [2:0]  dac_ref;
    logic [4:0]  dac_val;
    logic [31:0] next_cmd0;
    logic [31:0] next_cmd1;
    logic        next_exec_pend;
    logic        next_resp_valid;
    logic [7:0]  next_resp [0:9];
    logic [4:0]  next_clk_cfg;
    logic [2:0]  next_dac_ref;
    logic [4:0]  next_dac_val;
    logic        executing;
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  b4;

    assign executing = ce_i && exec_pend;
    assign op        = cmd0[7:0];
    assign b2        = cmd0[23:16];
    assign b3        = cmd0[31:24];
    assign b4        = cmd1[7:0];

    always_comb
    begin
        next_cmd0       = cmd0;
        next_cmd1       = cmd1;
        next_exec_pend  = exec_pend;
        next_resp_valid = resp_valid;
        next_clk_cfg    = clk_cfg;
        next_dac_ref    = dac_ref;
        next_dac_val    = dac_val;
        for (int k = 0; k < gpio_read_and_runtime_settings_cmd_pkg::RESP_BYTES; k++)
        begin
            next_resp[k] = resp[k];
        end
        if (do_write)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (w_strb[k] && wr_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_CMD0)
                    next_cmd0[8*k +: 8] = w_data[8*k +: 8];
                else if (w_strb[k] && wr_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_CMD1)
                    next_cmd1[8*k +: 8] = w_data[8*k +: 8];
            end
            if (wr_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_CTRL && w_strb[0]
                && w_data[gpio_read_and_runtime_settings_cmd_pkg::CTRL_GO_BIT])
                next_exec_pend = 1'b1;
            else if (wr_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_STATUS && w_strb[0]
                     && w_data[gpio_read_and_runtime_settings_cmd_pkg::STAT_VALID_BIT])
                next_resp_valid = 1'b0;
        end
        if (executing)
        begin
            // a new response always wins over a clear in the same cycle
            next_exec_pend  = 1'b0;
            next_resp_valid = 1'b1;
            for (int k = 0; k < gpio_read_and_runtime_settings_cmd_pkg::RESP_BYTES; k++)
            begin
                next_resp[k] = 8'h00;
            end
            next_resp[0] = op;
            if (op == gpio_read_and_runtime_settings_cmd_pkg::CMD_GET_PINS)
            begin
                next_resp[1] = gpio_read_and_runtime_settings_cmd_pkg::RESP_OK;
                for (int i = 0; i < gpio_read_and_runtime_settings_cmd_pkg::PIN_COUNT; i++)
                begin
                    next_resp[2+2*i] = general_pin_is_gpio_i[i] ? {7'h00, lvl_sync[i]}
                        : gpio_read_and_runtime_settings_cmd_pkg::MARK_LEVEL;
                    next_resp[3+2*i] = general_pin_is_gpio_i[i]
                        ? {7'h00, general_pin_is_input_i[i]}
                        : gpio_read_and_runtime_settings_cmd_pkg::MARK_DIR;
                end
            end
            else if (op == gpio_read_and_runtime_settings_cmd_pkg::CMD_SET_SETTINGS)
            begin
                // byte 1 is never looked at
                next_resp[1] = gpio_read_and_runtime_settings_cmd_pkg::RESP_OK;
                if (b2[gpio_read_and_runtime_settings_cmd_pkg::LOAD_BIT])
                    next_clk_cfg = b2[4:0];
                if (b3[gpio_read_and_runtime_settings_cmd_pkg::LOAD_BIT])
                    next_dac_ref = b3[2:0];
                if (b4[gpio_read_and_runtime_settings_cmd_pkg::LOAD_BIT])
                    next_dac_val = b4[4:0];
            end
            else
            begin
                next_resp[1] = gpio_read_and_runtime_settings_cmd_pkg::RESP_UNSUPPORTED;
            end
        end
        if (!ce_i)
        begin
            next_exec_pend = exec_pend;
        end
    end

    // defaults are constants: nothing survives a reset
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cmd0       <= 32'h0000_0000;
            cmd1       <= 32'h0000_0000;
            exec_pend  <= 1'b0;
            resp_valid <= 1'b0;
            clk_cfg    <= gpio_read_and_runtime_settings_cmd_pkg::RST_CLK_CFG;
            dac_ref    <= gpio_read_and_runtime_settings_cmd_pkg::RST_DAC_REF;
            dac_val    <= gpio_read_and_runtime_settings_cmd_pkg::RST_DAC_VALUE;
            for (int k = 0; k < 10; k++)
            begin
                resp[k] <= 8'h00;
            end
        end
        else if (ce_i)
        begin
            cmd0       <= next_cmd0;
            cmd1       <= next_cmd1;
            exec_pend  <= next_exec_pend;
            resp_valid <= next_resp_valid;
            clk_cfg    <= next_clk_cfg;
            dac_ref    <= next_dac_ref;
            dac_val    <= next_dac_val;
            for (int k = 0; k < 10; k++)
            begin
                resp[k] <= next_resp[k];
            end
        end
    end

    assign clk_out_divider_o   = clk_cfg[2:0];
    assign clk_out_duty_o      = clk_cfg[4:3];
    assign dac_vref_level_o    = dac_ref[2:1];
    assign dac_vref_internal_o = dac_ref[0];
    assign dac_value_o         = dac_val;

    // ==========================================================
    // axi read channel
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [7:0]  rd_word;

    assign s_axi_arready_o = ce_i && !rvalid;
    assign s_axi_rvalid_o  = rvalid;
    assign s_axi_rdata_o   = rdata;
    assign s_axi_rresp_o   = rresp;
    assign rd_word         = {s_axi_araddr_i[7:2], 2'b00};

    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (ce_i && rvalid && s_axi_rready_i)
            next_rvalid = 1'b0;
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            next_rvalid = 1'b1;
            next_rresp  = gpio_read_and_runtime_settings_cmd_pkg::AXI_OKAY;
            next_rdata  = 32'h0000_0000;
            if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_CMD0)
                next_rdata = cmd0;
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_CMD1)
                next_rdata = cmd1;
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_CTRL)
                next_rdata = 32'h0000_0000;
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_STATUS)
            begin
                next_rdata[gpio_read_and_runtime_settings_cmd_pkg::STAT_VALID_BIT] = resp_valid;
                next_rdata[gpio_read_and_runtime_settings_cmd_pkg::STAT_BUSY_BIT]  = exec_pend;
            end
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_RESP0)
                next_rdata = {resp[3], resp[2], resp[1], resp[0]};
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_RESP1)
                next_rdata = {resp[7], resp[6], resp[5], resp[4]};
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_RESP2)
                next_rdata = {16'h0000, resp[9], resp[8]};
            else if (rd_word == gpio_read_and_runtime_settings_cmd_pkg::OFF_SETTINGS)
            begin
                next_rdata[gpio_read_and_runtime_settings_cmd_pkg::SET_CLK_LSB +: 5] = clk_cfg;
                next_rdata[gpio_read_and_runtime_settings_cmd_pkg::SET_REF_LSB +: 3] = dac_ref;
                next_rdata[gpio_read_and_runtime_settings_cmd_pkg::SET_DAC_LSB +: 5] = dac_val;
            end
            else
                next_rresp = gpio_read_and_runtime_settings_cmd_pkg::AXI_SLVERR;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= 2'h0;
        end
        else
        begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end

    // ==========================================================
    // checks
    property p_get_echo;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h51 |=> resp[0] == 8'h51 && resp[1] == 8'h00;
    endproperty
    a_get_echo: assert property (p_get_echo)
        else $error("pin-read answer header wrong");

    property p_level_marker;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h51 |=> resp[8] == ($past(general_pin_is_gpio_i[3])
            ? {7'h00, $past(lvl_sync[3])} : 8'hEE);
    endproperty
    a_level_marker: assert property (p_level_marker)
        else $error("pin level byte wrong");

    property p_dir_marker;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h51 && !general_pin_is_gpio_i[1] |=> resp[5] == 8'hEF;
    endproperty
    a_dir_marker: assert property (p_dir_marker)
        else $error("direction marker missing");

    property p_set_ok;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h60 |=> resp[1] == 8'h00 && resp_valid && !exec_pend;
    endproperty
    a_set_ok: assert property (p_set_ok)
        else $error("settings command not acknowledged");

    property p_clk_load;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h60 |=> clk_cfg == ($past(b2[7]) ? $past(b2[4:0])
            : $past(clk_cfg));
    endproperty
    a_clk_load: assert property (p_clk_load)
        else $error("clock config load wrong");

    property p_ref_load;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h60 |=> dac_ref == ($past(b3[7]) ? $past(b3[2:0])
            : $past(dac_ref));
    endproperty
    a_ref_load: assert property (p_ref_load)
        else $error("dac reference load wrong");

    property p_val_load;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        executing && op == 8'h60 |=> dac_val == ($past(b4[7]) ? $past(b4[4:0])
            : $past(dac_val));
    endproperty
    a_val_load: assert property (p_val_load)
        else $error("dac value load wrong");

    property p_quiet;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !executing |=> $stable(clk_cfg) && $stable(dac_ref) && $stable(dac_val);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("setting changed without a command");

    property p_one_response;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        exec_pend && ce_i |=> resp_valid ##1 !exec_pend || $past(do_write);
    endproperty
    a_one_response: assert property (p_one_response)
        else $error("response flag not raised");

endmodule : gpio_read_and_runtime_settings_cmd

/* hw/gpio_read_and_runtime_settings_cmd_pkg.sv */
package gpio_read_and_runtime_settings_cmd_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFF_CMD0     = 8'h00;
    localparam logic [7:0] OFF_CMD1     = 8'h04;
    localparam logic [7:0] OFF_CTRL     = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0C;
    localparam logic [7:0] OFF_RESP0    = 8'h10;
    localparam logic [7:0] OFF_RESP1    = 8'h14;
    localparam logic [7:0] OFF_RESP2    = 8'h18;
    localparam logic [7:0] OFF_SETTINGS = 8'h1C;
    // ==========================================================
    // field positions
    localparam int CTRL_GO_BIT    = 0;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_BUSY_BIT  = 1;
    localparam int LOAD_BIT       = 7;
    localparam int SET_CLK_LSB    = 0;
    localparam int SET_REF_LSB    = 8;
    localparam int SET_DAC_LSB    = 16;
    // ==========================================================
    // command and response codes
    localparam logic [7:0] CMD_GET_PINS     = 8'h51;
    localparam logic [7:0] CMD_SET_SETTINGS = 8'h60;
    localparam logic [7:0] RESP_OK          = 8'h00;
    localparam logic [7:0] RESP_UNSUPPORTED = 8'hFF;
    localparam logic [7:0] MARK_LEVEL       = 8'hEE;
    localparam logic [7:0] MARK_DIR         = 8'hEF;
    localparam int         RESP_BYTES       = 10;
    localparam int         PIN_COUNT        = 4;
    // ==========================================================
    // setting encodings
    localparam logic [1:0] DUTY_0PCT  = 2'h3;
    localparam logic [1:0] DUTY_25PCT = 2'h2;
    localparam logic [1:0] DUTY_50PCT = 2'h1;
    localparam logic [1:0] DUTY_75PCT = 2'h0;
    localparam logic [1:0] VREF_4V096 = 2'h3;
    localparam logic [1:0] VREF_2V048 = 2'h2;
    localparam logic [1:0] VREF_1V024 = 2'h1;
    localparam logic [1:0] VREF_OFF   = 2'h0;
    // ==========================================================
    // values after reset, then axi response codes
    localparam logic [4:0] RST_CLK_CFG   = 5'h00;
    localparam logic [2:0] RST_DAC_REF   = 3'h0;
    localparam logic [4:0] RST_DAC_VALUE = 5'h00;
    localparam logic [1:0] AXI_OKAY      = 2'h0;
    localparam logic [1:0] AXI_SLVERR    = 2'h2;
endpackage : gpio_read_and_runtime_settings_cmd_pkg

/* testbench/pin_env_model.sv */
`timescale 1ns/100ps
// ==========================================================
// pin environment beside the block
module pin_env_model (
    input  wire logic        sys_clk_i,
    input  wire logic [11:0] pattern_i,
    output logic [3:0]       level_o = 4'h0,
    output logic [3:0]       is_gpio_o = 4'h0,
    output logic [3:0]       is_input_o = 4'h0
);
    logic [3:0] churn = 4'h0;
    // non-gpio pins wiggle, so their level must never leak out
    always @(posedge sys_clk_i)
    begin
        churn      <= ~churn;
        is_gpio_o  <= pattern_i[7:4];
        is_input_o <= pattern_i[3:0];
        level_o    <= (pattern_i[11:8] & pattern_i[7:4])
                    | (churn & ~pattern_i[7:4]);
    end
endmodule : pin_env_model

/* testbench/gpio_read_and_runtime_settings_cmd_tb_top.sv */
`timescale 1ns/100ps
module gpio_read_and_runtime_settings_cmd_tb_top;
    // ======================================================
    // stimulus and observed signals
    logic        clk = 1'h0;
    logic        rstn = 1'h0;
    logic        ce = 1'h1;
    logic [7:0]  awa = 8'h00;
    logic [31:0] wd = 32'h0;
    logic        awv = 1'h0;
    logic        wv = 1'h0;
    logic        br = 1'h0;
    logic [7:0]  ara = 8'h00;
    logic        arv = 1'h0;
    logic        rr = 1'h0;
    logic [3:0]  ws = 4'hF;
    logic [11:0] pat = 12'h000;
    logic        awr, wr, bv, arr, rv, din;
    logic [1:0]  bresp, rresp, duty, lvl;
    logic [2:0]  div;
    logic [4:0]  dac;
    logic [31:0] rd;
    logic [3:0]  p_lvl, p_gpio, p_inp;
    logic [4:0]  e_clk = 5'h00;
    logic [2:0]  e_ref = 3'h0;
    logic [4:0]  e_dac = 5'h00;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    // rows: command word 0, command byte 4, pins {level,gpio,input},
    // then the settings expected after the row {clock, ref, dac}
    logic [64:0] rows [8] = '{
        {32'h00000051, 8'h00, 12'hAF5, 5'h00, 3'h0, 5'h00},
        {32'h00000051, 8'h00, 12'hF6C, 5'h00, 3'h0, 5'h00},
        {32'hFF9DAA60, 8'hFF, 12'h000, 5'h1D, 3'h7, 5'h1F},
        {32'h051F0060, 8'h6A, 12'h000, 5'h1D, 3'h7, 5'h1F},
        {32'h84820060, 8'h80, 12'h000, 5'h02, 3'h4, 5'h00},
        {32'h828B5560, 8'h85, 12'h000, 5'h0B, 3'h2, 5'h05},
        {32'h81900060, 8'h00, 12'h000, 5'h10, 3'h1, 5'h05},
        {32'h9F9F0033, 8'h9F, 12'h000, 5'h10, 3'h1, 5'h05}};

    gpio_read_and_runtime_settings_cmd gpio_read_and_runtime_settings_cmd_inst (
        .sys_clk_i(clk), .rstn_i(rstn), .ce_i(ce),
        .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .general_pin_level_i(p_lvl), .general_pin_is_gpio_i(p_gpio),
        .general_pin_is_input_i(p_inp), .clk_out_divider_o(div),
        .clk_out_duty_o(duty), .dac_vref_level_o(lvl),
        .dac_vref_internal_o(din), .dac_value_o(dac));

    pin_env_model pin_env_model_inst (
        .sys_clk_i(clk), .pattern_i(pat), .level_o(p_lvl),
        .is_gpio_o(p_gpio), .is_input_o(p_inp));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // ======================================================
    // bus master: signals move just after rising edges only
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] resp);
        logic ha, hw, hb;
        @(posedge clk);
        awa <= a;
        wd  <= d;
        awv <= 1'h1;
        wv  <= 1'h1;
        br  <= 1'h1;
        forever
        begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wr;
            hb = br && bv;
            resp = hb ? bresp : resp;
            @(posedge clk);
            awv <= ha ? 1'h0 : awv;
            wv  <= hw ? 1'h0 : wv;
            br  <= hb ? 1'h0 : br;
            if (hb)
                break;
        end
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
        logic ha, hr;
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        rr  <= 1'h1;
        forever
        begin
            @(negedge clk);
            ha = arv && arr;
            hr = rr && rv;
            d = hr ? rd : d;
            resp = hr ? rresp : resp;
            @(posedge clk);
            arv <= ha ? 1'h0 : arv;
            rr  <= hr ? 1'h0 : rr;
            if (hr)
                break;
        end
    endtask : rd_reg

    function automatic logic [95:0] exp_resp(input logic [7:0] op,
                                             input logic [3:0] l, g, n);
        logic [95:0] e;
        e = 96'h0;
        e[7:0] = op;
        if (op != gpio_read_and_runtime_settings_cmd_pkg::CMD_GET_PINS &&
            op != gpio_read_and_runtime_settings_cmd_pkg::CMD_SET_SETTINGS)
            e[15:8] = gpio_read_and_runtime_settings_cmd_pkg::RESP_UNSUPPORTED;
        if (op == gpio_read_and_runtime_settings_cmd_pkg::CMD_GET_PINS)
            for (int i = 0; i < 4; i++)
            begin
                e[16*i+16+:8] = g[i] ? {7'h00, l[i]} : 8'hEE;
                e[16*i+24+:8] = g[i] ? {7'h00, n[i]} : 8'hEF;
            end
        return e;
    endfunction : exp_resp

    task automatic chk_set;
        logic [31:0] d;
        logic [1:0]  r;
        rd_reg(gpio_read_and_runtime_settings_cmd_pkg::OFF_SETTINGS, d, r);
        check("settings", d, {11'h000, e_dac, 5'h00, e_ref, 3'h0, e_clk});
        check("divider", div, e_clk[2:0]);
        check("duty", duty, e_clk[4:3]);
        check("vref_level", lvl, e_ref[2:1]);
        check("vref_internal", din, e_ref[0]);
        check("dac", dac, e_dac);
    endtask : chk_set

    task automatic run_row(input logic [31:0] w0, input logic [7:0] w1,
                           input logic [11:0] p, input logic [12:0] x);
        logic [1:0]  r;
        logic [31:0] s, st;
        logic [95:0] e;
        pat <= p;
        wr_reg(8'h00, w0, r);
        wr_reg(8'h04, {24'h000000, w1}, r);
        wr_reg(8'h08, 32'h1, r);
        st = 32'h0;
        while (st[0] !== 1'h1)
            rd_reg(8'h0C, st, r);
        e = exp_resp(w0[7:0], p[11:8], p[7:4], p[3:0]);
        for (int i = 0; i < 3; i++)
        begin
            rd_reg(8'h10 + 8'(4 * i), s, r);
            check("response", s, e[32*i+:32]);
        end
        e_clk = x[12:8];
        e_ref = x[7:5];
        e_dac = x[4:0];
        chk_set();
        wr_reg(8'h0C, 32'h1, r);
        rd_reg(8'h0C, st, r);
        check("resp_valid", st[0], 1'h0);
    endtask : run_row

    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        for (int i = 0; i < 8; i++)
            run_row(rows[i][64:33], rows[i][32:25], rows[i][24:13],
                    rows[i][12:0]);
        // a reset in mid-run must drop every runtime setting
        @(posedge clk);
        rstn <= 1'h0;
        @(posedge clk);
        rstn <= 1'h1;
        e_clk = gpio_read_and_runtime_settings_cmd_pkg::RST_CLK_CFG;
        e_ref = gpio_read_and_runtime_settings_cmd_pkg::RST_DAC_REF;
        e_dac = gpio_read_and_runtime_settings_cmd_pkg::RST_DAC_VALUE;
        chk_set();
        rd_reg(8'h20, d, r);
        check("rresp", r, gpio_read_and_runtime_settings_cmd_pkg::AXI_SLVERR);
        check("rdata", d, 32'h0);
        wr_reg(8'h24, 32'h1, r);
        check("bresp", r, gpio_read_and_runtime_settings_cmd_pkg::AXI_SLVERR);
        // frozen enable: every ready drops, so no beat can slip in
        ce <= 1'h0;
        @(negedge clk);
        check("awready", awr, 1'h0);
        check("wready", wr, 1'h0);
        check("arready", arr, 1'h0);
        @(posedge clk);
        ce <= 1'h1;
        // one byte lane only: the other bytes keep their reset zero
        ws <= 4'h1;
        wr_reg(8'h00, 32'hAABBCCDD, r);
        ws <= 4'hF;
        rd_reg(8'h00, d, r);
        check("cmd0_lanes", d, 32'h000000DD);
        end_sim();
    end
endmodule : gpio_read_and_runtime_settings_cmd_tb_top
